// [verilog/cantb_pkg.sv]
// Shared constants and types for the CAN transmit buffer set
package cantb_pkg;
  // ==========================================================================
  // Geometry
  localparam int          NBUF        = 3;
  localparam int          ADDR_W      = 8;
  localparam int          TAG_W       = 29;
  localparam int          PRIO_W      = 8;
  localparam int          LEN_W       = 4;
  localparam logic [3:0]  MAX_LEN     = 4'h8;
  localparam int          NBYTE       = 4;
  // ==========================================================================
  // Register map: buffer n at n * 0x10, control and status behind them
  localparam logic [7:0]  BUF_SPAN    = 8'h30;
  localparam int          BUF_SEL_HI  = 5;
  localparam int          BUF_SEL_LO  = 4;
  localparam logic [3:0]  OFS_INFO    = 4'h0;
  localparam logic [3:0]  OFS_TAG     = 4'h4;
  localparam logic [3:0]  OFS_DATA    = 4'h8;
  localparam logic [7:0]  OFS_CTRL    = 8'h30;
  localparam logic [7:0]  OFS_STAT    = 8'h34;
  // ==========================================================================
  // Field positions
  localparam int          EXT_BIT     = 31;
  localparam int          RTR_BIT     = 30;
  localparam int          LEN_LO      = 16;
  localparam int          PRIO_LO     = 0;
  localparam int          TAG_LO      = 0;
  localparam int          CTRL_MODE   = 0;
  localparam int          CTRL_REQ_LO = 1;
  localparam int          STAT_REL_LO = 0;
  localparam int          STAT_BUSY   = 3;
  // ==========================================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {RK_INFO, RK_TAG, RK_DATA, RK_CTRL, RK_STAT, RK_NONE} cantb_reg_t;
  typedef enum logic {ST_IDLE, ST_SEND} cantb_state_t;
endpackage

// [verilog/cantb_select.sv]
// Picks the next buffer to send among those awaiting transmission
`timescale 1ns/1ps
module cantb_select
  import cantb_pkg::*;
(
  input  wire logic [NBUF-1:0]   pending,         // Buffers awaiting send
  input  wire logic              prio_mode,       // 1: by priority, 0: by tag
  input  wire logic [PRIO_W-1:0] prio [NBUF],     // Priority fields
  input  wire logic [TAG_W-1:0]  tag  [NBUF],     // Identifier fields
  output logic                   found,           // Some buffer pending
  output logic [1:0]             idx              // Winning buffer
);
  function automatic logic [TAG_W-1:0] key_of(input logic mode, input logic [PRIO_W-1:0] p,
                                                input logic [TAG_W-1:0] t);
    key_of = mode ? TAG_W'(p) : t;
  endfunction

  always_comb begin
    logic [TAG_W-1:0] best;
    best  = '0;
    found = 1'b0;
    idx   = 2'h0;
    // Strict compare in ascending order keeps the lowest number on a tie
    for (int i = 0; i < NBUF; i++) begin
      if (pending[i] && (!found || key_of(prio_mode, prio[i], tag[i]) < best)) begin
        found = 1'b1;
        idx   = 2'(i);
        best  = key_of(prio_mode, prio[i], tag[i]);
      end
    end
  end
endmodule

// [verilog/cantb_frame_fmt.sv]
// Turns a length code into the sent length and the byte enables
`timescale 1ns/1ps
module cantb_frame_fmt
  import cantb_pkg::*;
(
  input  wire logic [LEN_W-1:0] length_code,      // Length as software wrote it
  input  wire logic             remote,           // Remote frame carries no data
  output logic [LEN_W-1:0]      length_sent,      // Clamped length
  output logic [NBYTE-1:0]      byte_en           // Bytes of data word that go out
);
  function automatic logic [LEN_W-1:0] clamp(input logic [LEN_W-1:0] l);
    clamp = (l > MAX_LEN) ? MAX_LEN : l;
  endfunction

  always_comb begin
    length_sent = clamp(length_code);
    for (int b = 0; b < NBYTE; b++) begin
      byte_en[b] = !remote && (length_sent > LEN_W'(b));
    end
  end
endmodule

// [verilog/cantb_top.sv]
// CAN transmit buffer set: three locked-while-pending buffers behind AXI4-Lite
// Notes on behaviour
// - Buffer writes only while its status shows released
// - Info bit 31 set sends extended frame
// - Info bit 30 set sends remote frame
// - Length field bits 19..16, reset zero
// - Length above eight sends as eight
// - Priority mode: lowest priority field goes first
// - Ties go to lowest buffer number
// - Identifier bits 28..0 become frame identifier
// - Data bytes one..four, sent only if covered
// - Reserved bits read zero, written zero
// - Writes to locked buffer dropped without notice
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module cantb_top
  import cantb_pkg::*;
(
  input  wire logic              aclk,            // System clock
  input  wire logic              aresetn,         // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] awaddr,          // Write address
  input  wire logic              awvalid,         // Write address valid
  output logic                   awready,         // Write address ready
  input  wire logic [31:0]       wdata,           // Write data
  input  wire logic [3:0]        wstrb,           // Write byte strobes
  input  wire logic              wvalid,          // Write data valid
  output logic                   wready,          // Write data ready
  output logic [1:0]             bresp,           // Write response
  output logic                   bvalid,          // Write response valid
  input  wire logic              bready,          // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,          // Read address
  input  wire logic              arvalid,         // Read address valid
  output logic                   arready,         // Read address ready
  output logic [31:0]            rdata,           // Read data
  output logic [1:0]             rresp,           // Read response
  output logic                   rvalid,          // Read data valid
  input  wire logic              rready,          // Read data ready
  output logic                   frame_valid,     // Frame offered to engine
  output logic [1:0]             frame_buffer,    // Buffer being sent
  output logic                   frame_extended,  // Extended format
  output logic                   frame_remote,    // Remote frame
  output logic [TAG_W-1:0]       frame_tag,       // Identifier
  output logic [LEN_W-1:0]       frame_length,    // Length, at most eight
  output logic [NBYTE-1:0]       frame_byte_en,   // Data bytes that go out
  output logic [31:0]            frame_data,      // Bytes one to four
  input  wire logic              frame_done       // Engine finished frame
);
  // ==========================================================================
  // Storage
  logic              ext_reg  [NBUF];
  logic              rtr_reg  [NBUF];
  logic [LEN_W-1:0]  len_reg  [NBUF];
  logic [PRIO_W-1:0] prio_reg [NBUF];
  logic [TAG_W-1:0]  tag_reg  [NBUF];
  logic [31:0]       data_reg [NBUF];
  logic [NBUF-1:0]   pend_reg, pend_next;
  logic              mode_reg, aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic              arready_reg, rvalid_reg, fv_reg, fext_reg, frtr_reg;
  logic              sel_found, wr_fire, wr_ok, launch;
  cantb_state_t      state_reg;
  cantb_reg_t        wr_kind;
  logic [1:0]        act_reg, bresp_reg, rresp_reg, sel_idx, wr_buf;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg, rdata_reg, fdata_reg, info_m, tag_m;
  logic [3:0]        w_strb_reg;
  logic [TAG_W-1:0]  ftag_reg;
  logic [LEN_W-1:0]  flen_reg, sel_len;
  logic [NBYTE-1:0]  fben_reg, sel_ben;
  // ==========================================================================
  // Decode and word helpers
  function automatic cantb_reg_t reg_kind(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w        = {a[ADDR_W-1:2], 2'h0};
    reg_kind = RK_NONE;
    if (w == OFS_CTRL) begin
      reg_kind = RK_CTRL;
    end else if (w == OFS_STAT) begin
      reg_kind = RK_STAT;
    end else if (w < BUF_SPAN) begin
      if (w[3:0] == OFS_INFO) begin
        reg_kind = RK_INFO;
      end else if (w[3:0] == OFS_TAG) begin
        reg_kind = RK_TAG;
      end else if (w[3:0] == OFS_DATA) begin
        reg_kind = RK_DATA;
      end
    end
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < NBYTE; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction
  // Reserved info bits stay zero because only fields are ever packed
  function automatic logic [31:0] info_word(input int i);
    info_word = '0;
    info_word[EXT_BIT]             = ext_reg[i];
    info_word[RTR_BIT]             = rtr_reg[i];
    info_word[LEN_LO +: LEN_W]     = len_reg[i];
    info_word[PRIO_LO +: PRIO_W]   = prio_reg[i];
  endfunction
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    int i;
    i         = int'(a[BUF_SEL_HI:BUF_SEL_LO]);
    read_word = '0;
    unique case (reg_kind(a))
      RK_INFO: read_word = info_word(i);
      RK_TAG:  read_word[TAG_LO +: TAG_W] = tag_reg[i];
      RK_DATA: read_word = data_reg[i];
      RK_CTRL: read_word[CTRL_MODE] = mode_reg;
      RK_STAT: begin
        read_word[STAT_REL_LO +: NBUF] = ~pend_reg;
        read_word[STAT_BUSY]           = fv_reg;
      end
      RK_NONE: read_word = '0;
    endcase
  endfunction
  // ==========================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_kind = reg_kind(aw_addr_reg);
  assign wr_buf  = aw_addr_reg[BUF_SEL_HI:BUF_SEL_LO];
  assign wr_ok   = wr_fire && (wr_kind inside {RK_INFO, RK_TAG, RK_DATA}) && !pend_reg[wr_buf];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready_reg) begin
      aw_full_reg <= 1'b1;
      awready_reg <= 1'b0;
      aw_addr_reg <= awaddr;
    end else begin
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      awready_reg <= !aw_full_reg && !bvalid_reg;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && wready_reg) begin
      w_full_reg <= 1'b1;
      wready_reg <= 1'b0;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else begin
      if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
      wready_reg <= !w_full_reg && !bvalid_reg;
    end
  end
  // Locked writes still answer OKAY: the loss is silent by design
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_kind == RK_NONE || wr_kind == RK_STAT) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  // ==========================================================================
  // Buffer contents
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NBUF; i++) begin
        ext_reg[i]  <= 1'b0;
        rtr_reg[i]  <= 1'b0;
        len_reg[i]  <= '0;
        prio_reg[i] <= '0;
        tag_reg[i]  <= '0;
        data_reg[i] <= '0;
      end
    end else if (wr_ok) begin
      unique case (wr_kind)
        RK_INFO: begin
          ext_reg[wr_buf]  <= info_m[EXT_BIT];
          rtr_reg[wr_buf]  <= info_m[RTR_BIT];
          len_reg[wr_buf]  <= info_m[LEN_LO +: LEN_W];
          prio_reg[wr_buf] <= info_m[PRIO_LO +: PRIO_W];
        end
        RK_TAG: tag_reg[wr_buf] <= tag_m[TAG_LO +: TAG_W];
        RK_DATA: data_reg[wr_buf] <= merge(data_reg[wr_buf], w_data_reg, w_strb_reg);
        default: data_reg[wr_buf] <= data_reg[wr_buf];
      endcase
    end
  end
  always_comb begin
    info_m = merge(info_word(int'(wr_buf)), w_data_reg, w_strb_reg);
    tag_m  = merge({3'h0, tag_reg[wr_buf]}, w_data_reg, w_strb_reg);
  end
  // ==========================================================================
  // Control: mode and send requests; a request set beats a done clear
  always_comb begin
    pend_next = pend_reg;
    if (state_reg == ST_SEND && frame_done) begin
      pend_next[act_reg] = 1'b0;
    end
    if (wr_fire && wr_kind == RK_CTRL && w_strb_reg[0]) begin
      pend_next = pend_next | w_data_reg[CTRL_REQ_LO +: NBUF];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= '0;
      mode_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      if (wr_fire && wr_kind == RK_CTRL && w_strb_reg[0]) begin
        mode_reg <= w_data_reg[CTRL_MODE];
      end
    end
  end
  // ==========================================================================
  // AXI4-Lite read path: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= read_word(araddr);
      rresp_reg   <= (reg_kind(araddr) == RK_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end
  // ==========================================================================
  // Selection and the frame handed to the protocol engine
  cantb_select u_select (
    .pending   (pend_reg),
    .prio_mode (mode_reg),
    .prio      (prio_reg),
    .tag       (tag_reg),
    .found     (sel_found),
    .idx       (sel_idx)
  );
  cantb_frame_fmt u_fmt (
    .length_code (len_reg[sel_idx]),
    .remote      (rtr_reg[sel_idx]),
    .length_sent (sel_len),
    .byte_en     (sel_ben)
  );
  assign launch = (state_reg == ST_IDLE) && sel_found;
  // Buffer stays locked until the engine reports the frame finished
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      act_reg   <= 2'h0;
      fv_reg    <= 1'b0;
      fext_reg  <= 1'b0;
      frtr_reg  <= 1'b0;
      ftag_reg  <= '0;
      flen_reg  <= '0;
      fben_reg  <= '0;
      fdata_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (sel_found) begin
            state_reg <= ST_SEND;
            act_reg   <= sel_idx;
            fv_reg    <= 1'b1;
            fext_reg  <= ext_reg[sel_idx];
            frtr_reg  <= rtr_reg[sel_idx];
            ftag_reg  <= tag_reg[sel_idx];
            flen_reg  <= sel_len;
            fben_reg  <= sel_ben;
            for (int b = 0; b < NBYTE; b++) begin
              fdata_reg[b*8 +: 8] <= sel_ben[b] ? data_reg[sel_idx][b*8 +: 8] : 8'h00;
            end
          end
        end
        ST_SEND: begin
          if (frame_done) begin
            state_reg <= ST_IDLE;
            fv_reg    <= 1'b0;
          end
        end
      endcase
    end
  end
  assign awready        = awready_reg;
  assign wready         = wready_reg;
  assign bvalid         = bvalid_reg;
  assign bresp          = bresp_reg;
  assign arready        = arready_reg;
  assign rvalid         = rvalid_reg;
  assign rdata          = rdata_reg;
  assign rresp          = rresp_reg;
  assign frame_valid    = fv_reg;
  assign frame_buffer   = act_reg;
  assign frame_extended = fext_reg;
  assign frame_remote   = frtr_reg;
  assign frame_tag      = ftag_reg;
  assign frame_length   = flen_reg;
  assign frame_byte_en  = fben_reg;
  assign frame_data     = fdata_reg;
  // ==========================================================================
  // Checks
  logic lower_key, tie_lower, rd_info_reg;
  always_comb begin
    lower_key = 1'b0;
    tie_lower = 1'b0;
    for (int j = 0; j < NBUF; j++) begin
      if (pend_reg[j]) begin
        if (mode_reg ? prio_reg[j] < prio_reg[sel_idx] : tag_reg[j] < tag_reg[sel_idx]) begin
          lower_key = 1'b1;
        end
        if ((mode_reg ? prio_reg[j] == prio_reg[sel_idx] : tag_reg[j] == tag_reg[sel_idx])
            && j < int'(sel_idx)) begin
          tie_lower = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_info_reg <= 1'b0;
    end else if (arvalid && arready_reg) begin
      rd_info_reg <= (reg_kind(araddr) == RK_INFO);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_locked_data_kept: assert property (wr_fire && wr_kind == RK_DATA && pend_reg[wr_buf]
    |=> data_reg[$past(wr_buf)] == $past(data_reg[wr_buf])) else $error("locked buffer data changed");
  a_ext_sent: assert property (launch |=> frame_extended == $past(ext_reg[sel_idx]))
    else $error("frame format differs from buffer");
  a_remote_nodata: assert property (frame_valid && frame_remote |-> frame_byte_en == '0)
    else $error("remote frame enables data bytes");
  a_len_clamp: assert property (launch && len_reg[sel_idx] > MAX_LEN |=> frame_length == MAX_LEN)
    else $error("length above eight not clamped");
  a_prio_lowest: assert property (launch && mode_reg |-> !lower_key)
    else $error("priority mode chose a higher value");
  a_tie_order: assert property (launch |-> !tie_lower)
    else $error("tie not resolved to lowest buffer");
  a_tag_sent: assert property (launch |=> frame_valid && frame_tag == $past(tag_reg[sel_idx]))
    else $error("frame identifier differs from buffer");
  a_reserved_zero: assert property (rvalid && rd_info_reg |-> rdata[29:20] == '0 && rdata[15:8] == '0)
    else $error("reserved info bits read nonzero");
  a_locked_okay: assert property (wr_fire && wr_kind == RK_TAG && pend_reg[wr_buf]
    |=> bvalid && bresp == RESP_OKAY) else $error("locked write signalled");
  a_tag_order: assert property (launch && !mode_reg |-> !lower_key)
    else $error("identifier order violated");
  a_held_until_done: assert property (frame_valid && !frame_done |=> frame_valid && $stable(frame_buffer))
    else $error("frame dropped before done");
  c_locked_write: cover property (wr_fire && wr_kind == RK_INFO && pend_reg[wr_buf]);
  c_prio_launch:  cover property (launch && mode_reg && pend_reg == 3'h7);
  c_tag_launch:   cover property (launch && !mode_reg && pend_reg == 3'h7);
  c_clamp_remote: cover property (launch && rtr_reg[sel_idx] && len_reg[sel_idx] > MAX_LEN);
endmodule

// [tb/cantb_engine_model.sv]
// Protocol engine stand-in: finishes each offered frame after a set delay
`timescale 1ns/1ps
module cantb_engine_model (
  input  wire logic       aclk,        // System clock
  input  wire logic       aresetn,     // Synchronous reset, low
  input  wire logic       frame_valid, // Frame offered
  input  wire logic [7:0] hold,        // Cycles before finishing
  output logic            frame_done   // One-cycle finish pulse
);
  // ==========================================================
  // Delay counter
  logic [7:0] cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg    <= 8'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      // Hold off in the pulse cycle so one frame never finishes twice
      if (frame_valid && !frame_done) begin
        if (cnt_reg >= hold) begin
          frame_done <= 1'b1;
          cnt_reg    <= 8'h00;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule

// [tb/cantb_top_tb.sv]
// Self-checking bench for the CAN transmit buffer set
`timescale 1ns/1ps
module cantb_top_tb
  import cantb_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic frame_valid, frame_extended, frame_remote, frame_done;
  logic [7:0] awaddr, araddr, hold;
  logic [31:0] wdata, rdata, frame_data, rd, ri, rt;
  logic [3:0] wstrb, frame_length, frame_byte_en;
  logic [1:0] bresp, rresp, frame_buffer, rsp;
  logic [TAG_W-1:0] frame_tag;
  logic [31:0] cor[4] = '{32'h000f0000, 32'h40090000, 32'h80080000, 32'h00030000};
  int n_fail, tests_run;
  cantb_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .frame_valid(frame_valid), .frame_buffer(frame_buffer), .frame_extended(frame_extended),
    .frame_remote(frame_remote), .frame_tag(frame_tag), .frame_length(frame_length),
    .frame_byte_en(frame_byte_en), .frame_data(frame_data), .frame_done(frame_done));
  cantb_engine_model eng (.aclk(aclk), .aresetn(aresetn), .frame_valid(frame_valid),
    .hold(hold), .frame_done(frame_done));
  // ==========================================================
  // Clock and checking helpers
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ap, wp;
    ap = 1;
    wp = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    forever begin
      @(posedge aclk);
      if (!ap && !wp && bvalid)
        break;
      if (ap && awready) begin
        ap = 0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 0;
        wvalid <= 1'b0;
      end
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // ==========================================================
  // Frame side
  task automatic grab;
    @(posedge aclk);
    while (!frame_valid) @(posedge aclk);
  endtask
  task automatic wait_end;
    while (frame_valid) @(posedge aclk);
  endtask
  function automatic logic [3:0] xen(input logic [31:0] i);
    logic [3:0] e;
    for (int k = 0; k < 4; k++)
      e[k] = !i[RTR_BIT] && (i[19:16] > k);
    return e;
  endfunction
  function automatic logic [31:0] xdat(input logic [3:0] e, input logic [31:0] d);
    logic [31:0] x;
    for (int k = 0; k < 4; k++)
      x[8*k +: 8] = e[k] ? d[8*k +: 8] : 8'h00;
    return x;
  endfunction
  task automatic send(input int b, input logic [31:0] i, t, d);
    wr(8'(b * 16), i);
    wr(8'(b * 16 + 4), t);
    wr(8'(b * 16 + 8), d);
    wr(OFS_CTRL, 32'(2 << b));
    grab;
    chk(frame_buffer, b);
    chk(frame_extended, i[31]);
    chk(frame_remote, i[30]);
    chk(frame_tag, t[28:0]);
    chk(frame_length, (i[19:16] > 4'h8) ? 4'h8 : i[19:16]);
    chk(frame_byte_en, xen(i));
    chk(frame_data, xdat(xen(i), d));
    wait_end;
    rdr(OFS_STAT);
    chk(rd[b], 1'b1);
  endtask
  task automatic order(input logic m, input int p[3], t[3], x[3]);
    for (int j = 0; j < 3; j++) begin
      wr(8'(j * 16), 32'(p[j]));
      wr(8'(j * 16 + 4), 32'(t[j]));
    end
    wr(OFS_CTRL, {28'h0, 3'b111, m});
    for (int j = 0; j < 3; j++) begin
      grab;
      chk(frame_buffer, x[j]);
      wait_end;
    end
    $display("Order test mode %0d done", m);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, hold} = '0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(86));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int j = 0; j < 12; j++) begin
      rdr(8'(j / 3 * 16 + j % 3 * 4));
      chk(rd, (j == 10) ? 32'h7 : 32'h0);
    end
    rdr(OFS_STAT);
    chk(rd, 32'h7);
    rdr(8'h40);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h00, 32'hffffffff);
    rdr(8'h00);
    chk(rd, 32'hc00f00ff);
    wr(8'h04, 32'hffffffff);
    rdr(8'h04);
    chk(rd, 32'h1fffffff);
    wstrb <= 4'h5;
    wr(8'h28, 32'haabbccdd);
    wstrb <= 4'hf;
    rdr(8'h28);
    chk(rd, 32'h00bb00dd);
    wr(OFS_STAT, 32'h0);
    chk(rsp, RESP_SLVERR);
    $display("Reset and field test done");
    for (int j = 0; j < 16; j++) begin
      ri = {2'($urandom), 10'h0, 4'($urandom), 8'h0, 8'($urandom)};
      if (j < 4)
        ri = cor[j];
      rt = ri[31] ? ($urandom & 32'h1fffffff) : ($urandom & 32'h7ff);
      hold <= 8'($urandom_range(6));
      send($urandom_range(2), ri, rt, $urandom);
    end
    $display("Random frame test done");
    hold <= 8'd60;
    send(1, 32'h00020000, 32'h5, 32'h1234);
    wr(OFS_CTRL, 32'h4);
    grab;
    wr(8'h10, 32'h80000000);
    chk(rsp, RESP_OKAY);
    wr(8'h14, 32'h7ff);
    chk(rsp, RESP_OKAY);
    wr(8'h18, 32'hffffffff);
    rdr(8'h10);
    chk(rd, 32'h00020000);
    rdr(8'h18);
    chk(rd, 32'h1234);
    rdr(8'h14);
    chk(rd, 32'h5);
    rdr(OFS_STAT);
    chk(rd, 32'hd);
    wait_end;
    wr(8'h10, 32'h80000000);
    rdr(8'h10);
    chk(rd, 32'h80000000);
    $display("Lock test done");
    hold <= 8'd2;
    order(1'b1, '{5, 3, 3}, '{0, 9, 1}, '{1, 2, 0});
    order(1'b0, '{0, 9, 1}, '{7, 2, 2}, '{1, 2, 0});
    order(1'b1, '{4, 4, 4}, '{3, 2, 1}, '{0, 1, 2});
    rdr(OFS_CTRL);
    chk(rd, 32'h1);
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    give_verdict;
  end
endmodule
